// *** include/adcrw_pkg.sv ***
// Package for the converter result, window threshold and temporary byte registers
// Notes on behaviour
// (RQ1) Result low byte at base offset, high byte at next offset.
// (RQ2) Input above reference clamps a single 10-bit conversion to 0x3FF.
// (RQ3) Input below ground gives a single conversion of 0x000.
// (RQ4) Sixty-four saturated samples never accumulate above 0xFFC0.
// (RQ5) High byte holds bits 15:8; raw converter output is 10 bits.
// (RQ6) Low byte holds bits 7:0; zero is all zeros, full scale all ones.
// (RQ7) Writable 16-bit low threshold in the result's number format.
// (RQ8) Low threshold low byte at base, high byte at next offset.
// (RQ9) During accumulation only the final sum is compared with thresholds.
// (RQ10) Writable 16-bit high threshold for the window comparator.
// (RQ11) High threshold low byte at base, high byte at next offset.
// (RQ12) Duty bit resets to one: 0 gives 50 percent, 1 gives 25 percent.
// (RQ13) Eight-bit read/write temporary byte used for 16-bit accesses.
// (RQ14) Window mode: none, below, above, inside, outside; other codes reserved.
// (RQ15) Ready and window flags clear by writing one or reading result.
// (RQ16) One temporary byte is shared by every 16-bit register.
// (RQ17) Low read latches high into temp; low write waits for high write.
package adcrw_pkg;

  localparam logic [7:0] TEMP_OFF      = 8'h0D;
  localparam logic [7:0] RESULT_OFF    = 8'h10;
  localparam logic [7:0] WIN_LOW_OFF   = 8'h12;
  localparam logic [7:0] WIN_HIGH_OFF  = 8'h14;
  localparam logic [7:0] DUTY_OFF      = 8'h16;
  localparam logic [7:0] MODE_OFF      = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFF  = 8'h0A;
  localparam logic [7:0] IRQ_FLAG_OFF  = 8'h0B;
  localparam logic [7:0] HIGH_STEP     = 8'h01;

  localparam logic [7:0]  DUTY_RST     = 8'h01;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam logic [9:0]  CONV_MAX     = 10'h3FF;
  localparam logic [9:0]  CONV_MIN     = 10'h000;
  localparam logic [15:0] ACC_CEIL     = 16'hFFC0;
  localparam int          ACC_MAX_N    = 64;
  localparam int          CNT_W        = 7;
  localparam int          FLAG_READY   = 0;
  localparam int          FLAG_WINDOW  = 1;
  localparam logic [6:0]  N_ONE        = 7'h01;

  // Duty divider: four converter clock phases per cycle
  localparam logic [1:0]  DIV_LAST     = 2'h3;

  typedef enum logic [2:0] {
    ADCRW_WIN_NONE    = 3'h0,
    ADCRW_WIN_BELOW   = 3'h1,
    ADCRW_WIN_ABOVE   = 3'h2,
    ADCRW_WIN_INSIDE  = 3'h3,
    ADCRW_WIN_OUTSIDE = 3'h4
  } adcrw_mode_e;

  typedef enum logic [1:0] {
    ADCRW_IDLE = 2'h0,
    ADCRW_ACC  = 2'h1,
    ADCRW_DONE = 2'h3
  } adcrw_state_e;

  // One raw sample from the analog front end
  typedef struct packed {
    logic       valid;
    logic       over;
    logic       under;
    logic [9:0] code;
  } adcrw_sample_s;

endpackage

// *** logic/adcrw_regs.sv ***
// Result, window comparator, duty calibration and temporary byte registers
module adcrw_regs (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Register port
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  // Converter side
  input  wire adcrw_pkg::adcrw_sample_s sample_i,
  input  wire logic [6:0]             acc_num_i,
  output logic                        conv_clk_o,
  output logic                        irq_o
);

  adcrw_pkg::adcrw_state_e state_ff;
  logic [15:0] result_ff;
  logic [15:0] acc_ff;
  logic [6:0]  cnt_ff;
  logic [15:0] win_lt_ff;
  logic [15:0] win_ht_ff;
  logic [7:0]  temp_ff;
  logic        duty_ff;
  logic [2:0]  mode_ff;
  logic [1:0]  mask_ff;
  logic [1:0]  flag_ff;
  logic [1:0]  div_ff;
  logic [7:0]  rdata_ff;
  logic        irq_ff;
  logic        conv_clk_ff;
  logic        done_ff;

  logic [9:0]  sat_code;
  logic [15:0] nxt_sum;
  logic [6:0]  n_target;
  logic        last_sample;
  logic        win_hit;
  logic        res_read;
  logic [1:0]  flag_set;

  // Clamp each raw sample before it joins the sum
  always_comb begin
    if (sample_i.over) begin
      sat_code = adcrw_pkg::CONV_MAX; // [RQ2]
    end else if (sample_i.under) begin
      sat_code = adcrw_pkg::CONV_MIN; // [RQ3]
    end else begin
      sat_code = sample_i.code;
    end
  end

  // Counts beyond 64 are limited so the sum never exceeds 0xFFC0
  always_comb begin
    if (acc_num_i == 7'h00) begin
      n_target = adcrw_pkg::N_ONE;
    end else if (acc_num_i > 7'(adcrw_pkg::ACC_MAX_N)) begin
      n_target = 7'(adcrw_pkg::ACC_MAX_N); // [RQ4]
    end else begin
      n_target = acc_num_i;
    end
  end

  // 16 bits hold 64 x 0x3FF = 0xFFC0 without overflow
  assign nxt_sum     = ((state_ff == adcrw_pkg::ADCRW_ACC) ? acc_ff : 16'h0000)
                       + {6'h00, sat_code}; // [RQ4]
  assign last_sample = sample_i.valid && ((cnt_ff + adcrw_pkg::N_ONE) >= n_target);

  // Accumulation sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff  <= adcrw_pkg::ADCRW_IDLE;
      acc_ff    <= adcrw_pkg::WORD_RST;
      cnt_ff    <= 7'h00;
      result_ff <= adcrw_pkg::WORD_RST;
      done_ff   <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (sample_i.valid) begin
        if (last_sample) begin
          result_ff <= nxt_sum; // [RQ5] [RQ6]
          done_ff   <= 1'b1;
          acc_ff    <= adcrw_pkg::WORD_RST;
          cnt_ff    <= 7'h00;
          state_ff  <= adcrw_pkg::ADCRW_DONE;
        end else begin
          acc_ff   <= nxt_sum;
          cnt_ff   <= cnt_ff + adcrw_pkg::N_ONE;
          state_ff <= adcrw_pkg::ADCRW_ACC;
        end
      end else if (state_ff == adcrw_pkg::ADCRW_DONE) begin
        state_ff <= adcrw_pkg::ADCRW_IDLE;
      end
    end
  end

  // Window test on the finished result only
  always_comb begin
    case (adcrw_pkg::adcrw_mode_e'(mode_ff))
      adcrw_pkg::ADCRW_WIN_BELOW:   win_hit = result_ff < win_lt_ff;
      adcrw_pkg::ADCRW_WIN_ABOVE:   win_hit = result_ff > win_ht_ff;
      adcrw_pkg::ADCRW_WIN_INSIDE:  win_hit = (result_ff > win_lt_ff) && (result_ff < win_ht_ff);
      adcrw_pkg::ADCRW_WIN_OUTSIDE: win_hit = (result_ff < win_lt_ff) || (result_ff > win_ht_ff);
      default:                      win_hit = 1'b0; // [RQ14]
    endcase
  end

  assign flag_set[adcrw_pkg::FLAG_READY]  = done_ff;
  assign flag_set[adcrw_pkg::FLAG_WINDOW] = done_ff && win_hit; // [RQ9]
  assign res_read = rd_i && ((addr_i == adcrw_pkg::RESULT_OFF)
                    || (addr_i == adcrw_pkg::RESULT_OFF + adcrw_pkg::HIGH_STEP));

  // Sticky flags: a new event wins over a clear in the same cycle
  generate
    for (genvar g = 0; g < 2; g++) begin : g_flag
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flag_ff[g] <= 1'b0;
        end else if (flag_set[g]) begin
          flag_ff[g] <= 1'b1;
        end else if (res_read || (wr_i && addr_i == adcrw_pkg::IRQ_FLAG_OFF && wdata_i[g])) begin
          flag_ff[g] <= 1'b0; // [RQ15]
        end
      end
    end
  endgenerate

  // Control, threshold and temporary byte writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      win_lt_ff <= adcrw_pkg::WORD_RST;
      win_ht_ff <= adcrw_pkg::WORD_RST;
      temp_ff   <= adcrw_pkg::BYTE_RST;
      duty_ff   <= adcrw_pkg::DUTY_RST[0];
      mode_ff   <= 3'h0;
      mask_ff   <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        adcrw_pkg::TEMP_OFF:     temp_ff <= wdata_i; // [RQ13]
        adcrw_pkg::WIN_LOW_OFF:  temp_ff <= wdata_i; // [RQ17] [RQ16]
        adcrw_pkg::WIN_HIGH_OFF: temp_ff <= wdata_i; // [RQ17] [RQ16]
        adcrw_pkg::WIN_LOW_OFF + adcrw_pkg::HIGH_STEP: begin
          win_lt_ff <= {wdata_i, temp_ff}; // [RQ7] [RQ8] [RQ17]
        end
        adcrw_pkg::WIN_HIGH_OFF + adcrw_pkg::HIGH_STEP: begin
          win_ht_ff <= {wdata_i, temp_ff}; // [RQ10] [RQ11] [RQ17]
        end
        adcrw_pkg::DUTY_OFF:     duty_ff <= wdata_i[0]; // [RQ12]
        adcrw_pkg::MODE_OFF:     mode_ff <= wdata_i[2:0];
        adcrw_pkg::IRQ_MASK_OFF: mask_ff <= wdata_i[1:0];
        default: ;
      endcase
    end else if (rd_i) begin
      case (addr_i)
        adcrw_pkg::RESULT_OFF:   temp_ff <= result_ff[15:8]; // [RQ17] [RQ16]
        adcrw_pkg::WIN_LOW_OFF:  temp_ff <= win_lt_ff[15:8];
        adcrw_pkg::WIN_HIGH_OFF: temp_ff <= win_ht_ff[15:8];
        default: ;
      endcase
    end
  end

  // Read data; high bytes come from temp so a 16-bit read is coherent
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        adcrw_pkg::TEMP_OFF:     rdata_ff <= temp_ff;
        adcrw_pkg::RESULT_OFF:   rdata_ff <= result_ff[7:0]; // [RQ1] [RQ6]
        adcrw_pkg::RESULT_OFF + adcrw_pkg::HIGH_STEP:   rdata_ff <= temp_ff; // [RQ1] [RQ5]
        adcrw_pkg::WIN_LOW_OFF:  rdata_ff <= win_lt_ff[7:0];
        adcrw_pkg::WIN_LOW_OFF + adcrw_pkg::HIGH_STEP:  rdata_ff <= temp_ff;
        adcrw_pkg::WIN_HIGH_OFF: rdata_ff <= win_ht_ff[7:0];
        adcrw_pkg::WIN_HIGH_OFF + adcrw_pkg::HIGH_STEP: rdata_ff <= temp_ff;
        adcrw_pkg::DUTY_OFF:     rdata_ff <= {7'h00, duty_ff};
        adcrw_pkg::MODE_OFF:     rdata_ff <= {5'h00, mode_ff};
        adcrw_pkg::IRQ_MASK_OFF: rdata_ff <= {6'h00, mask_ff};
        adcrw_pkg::IRQ_FLAG_OFF: rdata_ff <= {6'h00, flag_ff};
        default:                 rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // Converter clock: high one phase of four, or two of four
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff      <= 2'h0;
      conv_clk_ff <= 1'b0;
    end else begin
      div_ff      <= div_ff + 2'h1;
      conv_clk_ff <= duty_ff ? (div_ff == adcrw_pkg::DIV_LAST)
                             : div_ff[0] ^ div_ff[1] ^ 1'b1 ? 1'b0 : 1'b1; // [RQ12]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(flag_ff & mask_ff);
    end
  end

  assign rdata_o    = rdata_ff;
  assign irq_o      = irq_ff;
  assign conv_clk_o = conv_clk_ff;

  // Assertions: accumulation and clamping
  sum_ceiling_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ4]
    result_ff <= adcrw_pkg::ACC_CEIL)
    else $error("Result above accumulation ceiling");

  acc_limit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ4]
    cnt_ff < 7'(adcrw_pkg::ACC_MAX_N))
    else $error("Sample counter beyond maximum count");

  clamp_high_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ2]
    (sample_i.valid && sample_i.over && acc_num_i <= 7'h01)
    |=> (result_ff == 16'h03FF))
    else $error("Over-range sample not clamped");

  clamp_low_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ3]
    (sample_i.valid && sample_i.under && !sample_i.over && acc_num_i <= 7'h01)
    |=> (result_ff == 16'h0000))
    else $error("Under-range sample not zero");

  raw_pass_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ5]
    (sample_i.valid && !sample_i.over && !sample_i.under && acc_num_i <= 7'h01
     && state_ff != adcrw_pkg::ADCRW_ACC)
    |=> (result_ff == {6'h00, $past(sample_i.code)}))
    else $error("Single sample not passed to result");

  acc_hold_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ9]
    !sample_i.valid |=> $stable(result_ff))
    else $error("Result moved without a sample");

  // Assertions: flags and interrupt
  ready_flag_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    last_sample |=> ##1 flag_ff[0])
    else $error("Ready flag not set after result");

  set_wins_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    done_ff |=> flag_ff[0])
    else $error("Clear beat a new result");

  read_clear_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    (rd_i && addr_i == adcrw_pkg::RESULT_OFF && !done_ff) |=> (flag_ff == 2'h0))
    else $error("Result read did not clear flags");

  w1c_clear_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    (wr_i && addr_i == adcrw_pkg::IRQ_FLAG_OFF && wdata_i[0] && !done_ff)
    |=> !flag_ff[0])
    else $error("Writing one did not clear ready flag");

  w0_keep_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    (wr_i && !rd_i && addr_i == adcrw_pkg::IRQ_FLAG_OFF && !wdata_i[0] && flag_ff[0])
    |=> flag_ff[0])
    else $error("Writing zero cleared ready flag");

  flag_read_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ15]
    (rd_i && addr_i == adcrw_pkg::IRQ_FLAG_OFF) |=> (rdata_o == {6'h00, $past(flag_ff)}))
    else $error("Flag read returned wrong value");

  irq_level_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 (irq_o == $past(|(flag_ff & mask_ff))))
    else $error("Interrupt does not follow masked flags");

  // Assertions: window comparator
  win_final_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ9]
    $rose(flag_ff[1]) |-> $past(done_ff))
    else $error("Window flag set without final result");

  mode_none_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff == 3'h0 && !flag_ff[1]) |=> !flag_ff[1])
    else $error("Window flag set with comparison off");

  mode_below_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff == 3'h1 && result_ff < win_lt_ff) |=> flag_ff[1])
    else $error("Below-low match missed");

  mode_above_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff == 3'h2 && result_ff > win_ht_ff) |=> flag_ff[1])
    else $error("Above-high match missed");

  mode_inside_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff == 3'h3 && result_ff > win_lt_ff && result_ff < win_ht_ff)
    |=> flag_ff[1])
    else $error("Inside match missed");

  mode_outside_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff == 3'h4 && (result_ff < win_lt_ff || result_ff > win_ht_ff))
    |=> flag_ff[1])
    else $error("Outside match missed");

  mode_rsvd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (done_ff && mode_ff > 3'h4 && !flag_ff[1]) |=> !flag_ff[1])
    else $error("Reserved mode set the window flag");

  mode_read_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ14]
    (rd_i && addr_i == adcrw_pkg::MODE_OFF) |=> (rdata_o == {5'h00, $past(mode_ff)}))
    else $error("Mode read returned wrong value");

  // Assertions: 16-bit access through the shared temporary byte
  low_latch_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ17]
    (rd_i && addr_i == adcrw_pkg::RESULT_OFF) |=> (temp_ff == $past(result_ff[15:8])))
    else $error("High byte not latched into temp");

  res_low_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ1]
    (rd_i && addr_i == adcrw_pkg::RESULT_OFF) |=> (rdata_o == $past(result_ff[7:0])))
    else $error("Result low byte read wrong");

  res_high_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ5]
    (rd_i && addr_i == adcrw_pkg::RESULT_OFF + adcrw_pkg::HIGH_STEP)
    |=> (rdata_o == $past(temp_ff)))
    else $error("Result high byte not taken from temp");

  lt_latch_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ16]
    (rd_i && addr_i == adcrw_pkg::WIN_LOW_OFF) |=> (temp_ff == $past(win_lt_ff[15:8])))
    else $error("Low threshold high byte not latched");

  ht_latch_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ16]
    (rd_i && addr_i == adcrw_pkg::WIN_HIGH_OFF) |=> (temp_ff == $past(win_ht_ff[15:8])))
    else $error("High threshold high byte not latched");

  lt_low_rd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ8]
    (rd_i && addr_i == adcrw_pkg::WIN_LOW_OFF) |=> (rdata_o == $past(win_lt_ff[7:0])))
    else $error("Low threshold low byte read wrong");

  lt_high_rd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ8]
    (rd_i && addr_i == adcrw_pkg::WIN_LOW_OFF + adcrw_pkg::HIGH_STEP)
    |=> (rdata_o == $past(temp_ff)))
    else $error("Low threshold high byte not from temp");

  ht_low_rd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ11]
    (rd_i && addr_i == adcrw_pkg::WIN_HIGH_OFF) |=> (rdata_o == $past(win_ht_ff[7:0])))
    else $error("High threshold low byte read wrong");

  ht_high_rd_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ11]
    (rd_i && addr_i == adcrw_pkg::WIN_HIGH_OFF + adcrw_pkg::HIGH_STEP)
    |=> (rdata_o == $past(temp_ff)))
    else $error("High threshold high byte not from temp");

  thr_atomic_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ8]
    (wr_i && addr_i == adcrw_pkg::WIN_LOW_OFF) |=> $stable(win_lt_ff))
    else $error("Low threshold changed on low byte write");

  high_hold_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ11]
    (wr_i && addr_i == adcrw_pkg::WIN_HIGH_OFF) |=> $stable(win_ht_ff))
    else $error("High threshold changed on low byte write");

  low_commit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ7]
    (wr_i && addr_i == adcrw_pkg::WIN_LOW_OFF + adcrw_pkg::HIGH_STEP)
    |=> (win_lt_ff == {$past(wdata_i), $past(temp_ff)}))
    else $error("Low threshold not written atomically");

  thr_commit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ11]
    (wr_i && addr_i == adcrw_pkg::WIN_HIGH_OFF + adcrw_pkg::HIGH_STEP)
    |=> (win_ht_ff == {$past(wdata_i), $past(temp_ff)}))
    else $error("High threshold not written atomically");

  temp_write_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ13]
    (wr_i && addr_i == adcrw_pkg::TEMP_OFF) |=> (temp_ff == $past(wdata_i)))
    else $error("Temporary byte write lost");

  temp_read_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ13]
    (rd_i && addr_i == adcrw_pkg::TEMP_OFF) |=> (rdata_o == $past(temp_ff)))
    else $error("Temporary byte read wrong");

  rdata_idle_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> (rdata_o == 8'h00))
    else $error("Read data not zero without a read");

  // Assertions: converter clock duty
  duty_write_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12]
    (wr_i && addr_i == adcrw_pkg::DUTY_OFF) |=> (duty_ff == $past(wdata_i[0])))
    else $error("Duty bit write lost");

  duty_read_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12]
    (rd_i && addr_i == adcrw_pkg::DUTY_OFF) |=> (rdata_o == {7'h00, $past(duty_ff)}))
    else $error("Duty bit read wrong");

  duty_quarter_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12]
    (conv_clk_ff && duty_ff) |=> !conv_clk_ff)
    else $error("Quarter duty clock high too long");

  duty_half_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RQ12]
    (!duty_ff && div_ff == 2'h1) |=> conv_clk_ff)
    else $error("Half duty clock not high");

endmodule // adcrw_regs

// *** tb/test_adcrw_regs.sv ***
// Self-checking bench for the result, window and temporary byte registers
module test_adcrw_regs;
  timeunit 1ns;
  timeprecision 1ns;

  logic                     clk_i     = 1'b0;
  logic                     rst_n_i   = 1'b0;
  logic [7:0]               addr_i    = 8'h00;
  logic [7:0]               wdata_i   = 8'h00;
  logic                     wr_i      = 1'b0;
  logic                     rd_i      = 1'b0;
  logic [7:0]               rdata_o;
  adcrw_pkg::adcrw_sample_s sample_i  = '0;
  logic [6:0]               acc_num_i = 7'h01;
  logic                     conv_clk_o;
  logic                     irq_o;
  int                       fails       = 0;
  int                       checks_done = 0;
  int                       cyc         = 0;
  logic [15:0]              v;
  logic [7:0]               b;

  adcrw_regs dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .sample_i(sample_i), .acc_num_i(acc_num_i),
    .conv_clk_o(conv_clk_o), .irq_o(irq_o)
  );

  always #20 clk_i = ~clk_i;

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    logic [7:0] lo, hi;
    rd(a, lo);
    rd(a + 8'h01, hi);
    d = {hi, lo};
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask

  // Flags settle two cycles and the interrupt three cycles after the sample
  task automatic send(input logic o, input logic u, input logic [9:0] c);
    @(posedge clk_i);
    sample_i <= {1'b1, o, u, c};
    @(posedge clk_i);
    sample_i <= '0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic t_reset;
    rd(adcrw_pkg::TEMP_OFF, b);  chk({8'h00, b}, 16'h0000);
    rd(adcrw_pkg::DUTY_OFF, b); chk({8'h00, b}, 16'h0001);
    rd16(adcrw_pkg::RESULT_OFF, v);   chk(v, 16'h0000);
    rd16(adcrw_pkg::WIN_LOW_OFF, v);  chk(v, 16'h0000);
    rd16(adcrw_pkg::WIN_HIGH_OFF, v); chk(v, 16'h0000);
    wr(8'h30, 8'hA5);
    rd(8'h30, b); chk({8'h00, b}, 16'h0000);
  endtask

  task automatic t_thresh;
    wr16(adcrw_pkg::WIN_LOW_OFF, 16'h1234);
    rd16(adcrw_pkg::WIN_LOW_OFF, v); chk(v, 16'h1234);
    wr(adcrw_pkg::WIN_HIGH_OFF, 8'hCD);
    rd(adcrw_pkg::TEMP_OFF, b); chk({8'h00, b}, 16'h00CD);
    wr(adcrw_pkg::WIN_HIGH_OFF + 8'h01, 8'hAB);
    rd16(adcrw_pkg::WIN_HIGH_OFF, v); chk(v, 16'hABCD);
    // Low byte alone must not reach the threshold before its high byte
    wr(adcrw_pkg::WIN_HIGH_OFF, 8'hEF);
    rd(adcrw_pkg::WIN_HIGH_OFF, b); chk({8'h00, b}, 16'h00CD);
    wr(adcrw_pkg::TEMP_OFF, 8'h56);
    wr(adcrw_pkg::WIN_LOW_OFF + 8'h01, 8'h78);
    rd16(adcrw_pkg::WIN_LOW_OFF, v); chk(v, 16'h7856);
  endtask

  task automatic t_conv;
    acc_num_i <= 7'h01;
    send(1'b1, 1'b0, 10'h155); rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'h03FF);
    send(1'b0, 1'b1, 10'h155); rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'h0000);
    send(1'b1, 1'b1, 10'h000); rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'h03FF);
    send(1'b0, 1'b0, 10'h2A5); rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'h02A5);
    rd(adcrw_pkg::TEMP_OFF, b); chk({8'h00, b}, 16'h0002);
    acc_num_i <= 7'h40;
    repeat (64) send(1'b1, 1'b0, 10'h000);
    rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'hFFC0);
  endtask

  task automatic win_one(input logic [2:0] m, input logic [9:0] c, input logic e);
    wr(adcrw_pkg::MODE_OFF, {5'h00, m});
    send(1'b0, 1'b0, c);
    rd(adcrw_pkg::IRQ_FLAG_OFF, b); chk({8'h00, b}, {14'h0000, e, 1'b1});
    rd16(adcrw_pkg::RESULT_OFF, v);
    rd(adcrw_pkg::IRQ_FLAG_OFF, b); chk({8'h00, b}, 16'h0000);
  endtask

  task automatic t_window;
    acc_num_i <= 7'h01;
    wr16(adcrw_pkg::WIN_LOW_OFF, 16'h0100);
    wr16(adcrw_pkg::WIN_HIGH_OFF, 16'h0200);
    win_one(3'h0, 10'h050, 1'b0);
    win_one(3'h1, 10'h050, 1'b1);
    win_one(3'h1, 10'h150, 1'b0);
    win_one(3'h2, 10'h250, 1'b1);
    win_one(3'h2, 10'h150, 1'b0);
    win_one(3'h3, 10'h150, 1'b1);
    win_one(3'h3, 10'h100, 1'b0);
    win_one(3'h4, 10'h050, 1'b1);
    win_one(3'h4, 10'h150, 1'b0);
    // Each sample alone is below the threshold, their sum is not
    wr16(adcrw_pkg::WIN_LOW_OFF, 16'h0150);
    wr(adcrw_pkg::MODE_OFF, 8'h01);
    acc_num_i <= 7'h02;
    send(1'b0, 1'b0, 10'h100);
    send(1'b0, 1'b0, 10'h100);
    rd(adcrw_pkg::IRQ_FLAG_OFF, b); chk({8'h00, b}, 16'h0001);
    rd16(adcrw_pkg::RESULT_OFF, v); chk(v, 16'h0200);
  endtask

  task automatic t_irq;
    acc_num_i <= 7'h01;
    wr(adcrw_pkg::MODE_OFF, 8'h00);
    wr(adcrw_pkg::IRQ_MASK_OFF, 8'h01);
    send(1'b0, 1'b0, 10'h001);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(adcrw_pkg::IRQ_FLAG_OFF, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(adcrw_pkg::IRQ_FLAG_OFF, 8'h01);
    repeat (2) @(posedge clk_i);
    chk({15'h0000, irq_o}, 16'h0000);
    wr(adcrw_pkg::IRQ_MASK_OFF, 8'h00);
    send(1'b0, 1'b0, 10'h001);
    chk({15'h0000, irq_o}, 16'h0000);
    rd(adcrw_pkg::IRQ_FLAG_OFF, b); chk({8'h00, b}, 16'h0001);
  endtask

  task automatic duty(input int exp);
    int n;
    n = 0;
    repeat (8) begin
      @(negedge clk_i);
      if (conv_clk_o === 1'b1) n++;
    end
    chk(16'(n), 16'(exp));
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_thresh();
    t_conv();
    t_window();
    t_irq();
    duty(2);
    wr(adcrw_pkg::DUTY_OFF, 8'h00);
    repeat (4) @(posedge clk_i);
    duty(4);
    final_report();
  end
endmodule // test_adcrw_regs
